// ==== servo_regs.svh ====
// register offsets, field positions, reset values and timing counts
// Notes on behaviour
// - over-speed fault while motor speed exceeds the set level, 0 to 20000 r/min.
// - over-speed level zero means 1.2 times the motor maximum speed.
// - effective over-load level never exceeds 115 percent of rating.
// - over-load level zero means a threshold of 115 percent.
// - travel fault when overrun exceeds travel range, 0.1 rev units, default 10.
// - input reading period 0.166, 0.333, 1 or 1.666 ms by input filter setting.
// - alarm clear recognised after 120 ms, or at input reading period when set to 1.
// - counter clear mode 0 ignores the counter clear input; range 0 to 4, default 3.
// - modes 1 and 2 hold deviation clear while input active; raw or filtered.
// - modes 3 and 4 clear once on rising edge; raw or filtered.
// - inhibit input honoured only when inhibit disable is 0; default 1 ignores it.
// - inhibit reading period 0.166, 0.333, 1 or 1.666 ms by inhibit filter setting.
// - inhibit filter 4 samples every 0.166 ms and takes each sample directly.
// - input filter, alarm clear time and inhibit filter apply only at power-up.
`ifndef SERVO_REGS_SVH
`define SERVO_REGS_SVH
`define CLK_NS 50
`define T_P0_NS 166000
`define T_P1_NS 333000
`define T_P2_NS 1000000
`define T_P3_NS 1666000
`define T_ACLR_NS 120000000
`define FILT_SAMPLES 3
`define OL_LIMIT_PCT 10'h073
`define OS_MUL 6
`define OS_DIV 5
`define RST_OVERLOAD 10'h000
`define RST_OVERSPEED 16'h0000
`define RST_TRAVEL 11'h00A
`define RST_IN_FILT 2'h0
`define RST_ACLR_TIME 1'h0
`define RST_CCLR_MODE 3'h3
`define RST_INH_DIS 1'h1
`define RST_INH_FILT 3'h0
`define OFS_OVERLOAD 8'h00
`define OFS_OVERSPEED 8'h04
`define OFS_TRAVEL 8'h08
`define OFS_IN_FILT 8'h0C
`define OFS_ACLR_TIME 8'h10
`define OFS_CCLR_MODE 8'h14
`define OFS_INH_DIS 8'h18
`define OFS_INH_FILT 8'h1C
`define OFS_STATUS 8'h20
`define OFS_MASK 8'h24
`define OFS_LIVE 8'h28
`define EVT_OVERSPEED 0
`define EVT_OVERLOAD 1
`define EVT_TRAVEL 2
`define EVT_ACLR 3
`define EVT_W 4
`endif

// ==== servo_pkg.sv ====
// types shared by the servo input conditioning block
package servo_pkg;
    typedef struct packed {
        logic [9:0] overload;
        logic [15:0] overspeed;
        logic [10:0] travel;
        logic [2:0] cclr_mode;
        logic inh_dis;
    } live_cfg_type;
    typedef struct packed {
        logic [1:0] in_filt;
        logic aclr_time;
        logic [2:0] inh_filt;
    } boot_cfg_type;
endpackage

// ==== servo_input_filter_protection.sv ====
// servo control input conditioning and protection checks
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "servo_regs.svh"
module servo_input_filter_protection #(
    parameter int FILT_N = `FILT_SAMPLES,
    parameter int P0_CYC = `T_P0_NS / `CLK_NS,
    parameter int P1_CYC = `T_P1_NS / `CLK_NS,
    parameter int P2_CYC = `T_P2_NS / `CLK_NS,
    parameter int P3_CYC = `T_P3_NS / `CLK_NS,
    parameter int ACLR_CYC = `T_ACLR_NS / `CLK_NS
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic POWER_UP,
    input wire logic ALARM_CLEAR_IN,
    input wire logic COUNTER_CLEAR_IN,
    input wire logic PULSE_INHIBIT_IN,
    input wire logic [15:0] MOTOR_SPEED,
    input wire logic [15:0] MOTOR_MAX_SPEED,
    input wire logic [9:0] LOAD_LEVEL,
    input wire logic [15:0] TRAVEL_OVERRUN,
    output logic ALARM_CLEAR,
    output logic DEV_CLEAR,
    output logic PULSE_INHIBIT,
    output logic OVERSPEED_FAULT,
    output logic OVERLOAD_FAULT,
    output logic TRAVEL_LIMIT_FAULT,
    output logic IRQ
);
    localparam logic [23:0] PER0 = 24'(P0_CYC - 1);
    localparam logic [23:0] PER1 = 24'(P1_CYC - 1);
    localparam logic [23:0] PER2 = 24'(P2_CYC - 1);
    localparam logic [23:0] PER3 = 24'(P3_CYC - 1);
    localparam logic [23:0] ACLR_LAST = 24'(ACLR_CYC - 1);

    servo_pkg::live_cfg_type cfg_r;
    servo_pkg::boot_cfg_type boot_r;
    servo_pkg::boot_cfg_type act_r;
    logic [`EVT_W-1:0] status_r, mask_r, evt;
    logic [2:0] pin_a_r, pin_b_r;
    logic [2:0] filt;
    logic [1:0] tick;
    logic [23:0] per [2];
    logic [23:0] aclr_cnt_r;
    logic aclr_rec_r;
    logic cclr_prev_r;

    // register write decode
    wire wr_overload = WR && ADDR == `OFS_OVERLOAD;
    wire wr_overspeed = WR && ADDR == `OFS_OVERSPEED;
    wire wr_travel = WR && ADDR == `OFS_TRAVEL;
    wire wr_in_filt = WR && ADDR == `OFS_IN_FILT;
    wire wr_aclr = WR && ADDR == `OFS_ACLR_TIME;
    wire wr_cclr = WR && ADDR == `OFS_CCLR_MODE;
    wire wr_inh_dis = WR && ADDR == `OFS_INH_DIS;
    wire wr_inh_filt = WR && ADDR == `OFS_INH_FILT;
    wire wr_mask = WR && ADDR == `OFS_MASK;
    wire rd_status = RD && ADDR == `OFS_STATUS;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cfg_r.overload <= `RST_OVERLOAD;
            cfg_r.overspeed <= `RST_OVERSPEED;
            cfg_r.travel <= `RST_TRAVEL;
            cfg_r.cclr_mode <= `RST_CCLR_MODE;
            cfg_r.inh_dis <= `RST_INH_DIS;
            boot_r <= {`RST_IN_FILT, `RST_ACLR_TIME, `RST_INH_FILT};
            mask_r <= '0;
        end else begin
            if (wr_overload) cfg_r.overload <= WDATA[9:0];
            if (wr_overspeed) cfg_r.overspeed <= WDATA[15:0];
            if (wr_travel) cfg_r.travel <= WDATA[10:0];
            if (wr_cclr) cfg_r.cclr_mode <= WDATA[2:0];
            if (wr_inh_dis) cfg_r.inh_dis <= WDATA[0];
            if (wr_in_filt) boot_r.in_filt <= WDATA[1:0];
            if (wr_aclr) boot_r.aclr_time <= WDATA[0];
            if (wr_inh_filt) boot_r.inh_filt <= WDATA[2:0];
            if (wr_mask) mask_r <= WDATA[`EVT_W-1:0];
        end
    end

    // written values wait here until the next control power-up
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            act_r <= {`RST_IN_FILT, `RST_ACLR_TIME, `RST_INH_FILT};
        end else if (POWER_UP) begin
            act_r <= boot_r;
        end
    end

    // pins come from the host side, so two flops before use
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pin_a_r <= '0;
            pin_b_r <= '0;
        end else begin
            pin_a_r <= {PULSE_INHIBIT_IN, COUNTER_CLEAR_IN, ALARM_CLEAR_IN};
            pin_b_r <= pin_a_r;
        end
    end

    // reading periods; inhibit setting 4 reuses the fastest period
    assign per[0] = act_r.in_filt == 2'h0 ? PER0 :
                    act_r.in_filt == 2'h1 ? PER1 :
                    act_r.in_filt == 2'h2 ? PER2 : PER3;
    assign per[1] = act_r.inh_filt == 3'h1 ? PER1 :
                    act_r.inh_filt == 3'h2 ? PER2 :
                    act_r.inh_filt == 3'h3 ? PER3 : PER0;

    for (genvar t = 0; t < 2; t++) begin : g_timer
        logic [23:0] cnt_r;
        wire hit = cnt_r >= per[t];
        always_ff @(posedge CLK or posedge RST) begin
            if (RST) begin
                cnt_r <= '0;
            end else begin
                cnt_r <= hit ? 24'h000000 : cnt_r + 24'h000001;
            end
        end
        assign tick[t] = hit;
    end

    // per-input majority-free filter: all samples must agree to move, except inhibit setting 4 takes each sample directly
    wire [2:0] ch_tick = {tick[1], tick[0], tick[0]};
    wire [2:0] direct = {act_r.inh_filt == 3'h4, 2'b00};
    for (genvar c = 0; c < 3; c++) begin : g_filt
        logic [FILT_N-1:0] hist_r;
        logic level_r;
        wire [FILT_N-1:0] hist_nxt = {hist_r[FILT_N-2:0], pin_b_r[c]};
        always_ff @(posedge CLK or posedge RST) begin
            if (RST) begin
                hist_r <= '0;
                level_r <= 1'b0;
            end else if (ch_tick[c]) begin
                hist_r <= hist_nxt;
                if (direct[c]) begin
                    level_r <= pin_b_r[c];
                end else if (&hist_nxt) begin
                    level_r <= 1'b1;
                end else if (~|hist_nxt) begin
                    level_r <= 1'b0;
                end
            end
        end
        assign filt[c] = level_r;
    end

    // alarm clear: long hold time rejects chatter on the reset button
    wire aclr_hit = aclr_cnt_r >= ACLR_LAST;
    wire aclr_rec_nxt = act_r.aclr_time ? filt[0] : (pin_b_r[0] && aclr_hit);
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            aclr_cnt_r <= '0;
            aclr_rec_r <= 1'b0;
        end else begin
            if (!pin_b_r[0]) begin
                aclr_cnt_r <= '0;
            end else if (!aclr_hit) begin
                aclr_cnt_r <= aclr_cnt_r + 24'h000001;
            end
            aclr_rec_r <= aclr_rec_nxt;
        end
    end

    // deviation counter clear
    wire cclr_raw = cfg_r.cclr_mode == 3'h1 || cfg_r.cclr_mode == 3'h3;
    wire cclr_src = cclr_raw ? pin_b_r[1] : filt[1];
    wire cclr_edge = cclr_src && !cclr_prev_r;
    wire cclr_lvl_mode = cfg_r.cclr_mode == 3'h1 || cfg_r.cclr_mode == 3'h2;
    wire cclr_edge_mode = cfg_r.cclr_mode == 3'h3 || cfg_r.cclr_mode == 3'h4;
    wire dev_clear_nxt = cclr_lvl_mode ? cclr_src :
                         cclr_edge_mode ? cclr_edge : 1'b0;

    wire inhibit_nxt = !cfg_r.inh_dis && filt[2];

    // protection thresholds
    wire [18:0] max_x6 = 19'(MOTOR_MAX_SPEED) * 19'(`OS_MUL);
    wire [18:0] os_auto = max_x6 / 19'(`OS_DIV);
    wire [18:0] os_thr = cfg_r.overspeed == 16'h0000 ? os_auto :
                         19'(cfg_r.overspeed);
    wire os_nxt = 19'(MOTOR_SPEED) > os_thr;
    wire ol_clamp = cfg_r.overload == 10'h000 || cfg_r.overload > `OL_LIMIT_PCT;
    wire [9:0] ol_thr = ol_clamp ? `OL_LIMIT_PCT : cfg_r.overload;
    wire ol_nxt = LOAD_LEVEL > ol_thr;
    wire tr_nxt = TRAVEL_OVERRUN > 16'(cfg_r.travel);

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cclr_prev_r <= 1'b0;
            ALARM_CLEAR <= 1'b0;
            DEV_CLEAR <= 1'b0;
            PULSE_INHIBIT <= 1'b0;
            OVERSPEED_FAULT <= 1'b0;
            OVERLOAD_FAULT <= 1'b0;
            TRAVEL_LIMIT_FAULT <= 1'b0;
        end else begin
            cclr_prev_r <= cclr_src;
            ALARM_CLEAR <= aclr_rec_r;
            DEV_CLEAR <= dev_clear_nxt;
            PULSE_INHIBIT <= inhibit_nxt;
            OVERSPEED_FAULT <= os_nxt;
            OVERLOAD_FAULT <= ol_nxt;
            TRAVEL_LIMIT_FAULT <= tr_nxt;
        end
    end

    // sticky status; a fault still present refills its bit on read
    always_comb begin
        evt = '0;
        evt[`EVT_OVERSPEED] = OVERSPEED_FAULT;
        evt[`EVT_OVERLOAD] = OVERLOAD_FAULT;
        evt[`EVT_TRAVEL] = TRAVEL_LIMIT_FAULT;
        evt[`EVT_ACLR] = ALARM_CLEAR;
    end
    wire [`EVT_W-1:0] status_nxt = (rd_status ? '0 : status_r) | evt;

    wire [31:0] live_word = {20'h00000, filt, pin_b_r, ALARM_CLEAR, DEV_CLEAR, PULSE_INHIBIT,
                             TRAVEL_LIMIT_FAULT, OVERLOAD_FAULT, OVERSPEED_FAULT};
    wire [31:0] rd_mux =
        ADDR == `OFS_OVERLOAD ? 32'(cfg_r.overload) :
        ADDR == `OFS_OVERSPEED ? 32'(cfg_r.overspeed) :
        ADDR == `OFS_TRAVEL ? 32'(cfg_r.travel) :
        ADDR == `OFS_IN_FILT ? 32'(boot_r.in_filt) :
        ADDR == `OFS_ACLR_TIME ? 32'(boot_r.aclr_time) :
        ADDR == `OFS_CCLR_MODE ? 32'(cfg_r.cclr_mode) :
        ADDR == `OFS_INH_DIS ? 32'(cfg_r.inh_dis) :
        ADDR == `OFS_INH_FILT ? 32'(boot_r.inh_filt) :
        ADDR == `OFS_STATUS ? 32'(status_r) :
        ADDR == `OFS_MASK ? 32'(mask_r) :
        ADDR == `OFS_LIVE ? live_word : 32'h00000000;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            status_r <= '0;
            IRQ <= 1'b0;
            RDATA <= '0;
        end else begin
            status_r <= status_nxt;
            IRQ <= |(status_r & mask_r);
            RDATA <= RD ? rd_mux : 32'h00000000;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence s_raw_rise;
        cfg_r.cclr_mode == 3'h3 && !pin_b_r[1] ##1 cfg_r.cclr_mode == 3'h3 && pin_b_r[1];
    endsequence

    chk_overspeed_trip: assert property (
        cfg_r.overspeed != 16'h0000 && MOTOR_SPEED > cfg_r.overspeed |=> OVERSPEED_FAULT)
        else $error("over-speed fault missed");
    chk_overspeed_auto: assert property (
        cfg_r.overspeed == 16'h0000 &&
        20'(MOTOR_SPEED) * 20'h5 > 20'(MOTOR_MAX_SPEED) * 20'h6 |=> OVERSPEED_FAULT)
        else $error("over-speed auto level wrong");
    chk_overload_clamp: assert property (
        LOAD_LEVEL > 10'h073 |=> OVERLOAD_FAULT)
        else $error("over-load above clamp");
    chk_overload_zero: assert property (
        cfg_r.overload == 10'h000 && LOAD_LEVEL == 10'h074 |=> OVERLOAD_FAULT)
        else $error("over-load default missed");
    chk_travel_limit: assert property (
        TRAVEL_OVERRUN > 16'(cfg_r.travel) |=> TRAVEL_LIMIT_FAULT)
        else $error("travel fault missed");
    chk_tick_gap: assert property (
        tick[0] |=> !tick[0] [*8])
        else $error("reading period too short");
    chk_clear_ignored: assert property (
        cfg_r.cclr_mode == 3'h0 |=> !DEV_CLEAR)
        else $error("counter clear not ignored");
    chk_level_clear: assert property (
        cfg_r.cclr_mode == 3'h1 && pin_b_r[1] |=> DEV_CLEAR)
        else $error("level clear missed");
    chk_edge_clear: assert property (
        s_raw_rise |=> DEV_CLEAR ##1 (!DEV_CLEAR || cfg_r.cclr_mode != 3'h3))
        else $error("edge clear wrong");
    chk_inhibit_off: assert property (
        cfg_r.inh_dis |=> !PULSE_INHIBIT)
        else $error("inhibit not ignored");
    chk_boot_hold: assert property (
        !POWER_UP |=> $stable(act_r))
        else $error("setting applied without power-up");
    chk_alarm_hold: assert property (
        !act_r.aclr_time && !aclr_hit |=> !aclr_rec_r)
        else $error("alarm clear before recognition time");
    chk_inhibit_hold: assert property (
        !tick[1] |=> $stable(filt[2]))
        else $error("inhibit level moved between readings");
    chk_direct_inhibit: assert property (
        act_r.inh_filt == 3'h4 && tick[1] |=> filt[2] == $past(pin_b_r[2]))
        else $error("direct inhibit sample not taken");
    chk_filter_hold: assert property (
        !tick[0] |=> $stable(filt[1:0]))
        else $error("filtered level moved between readings");
endmodule
`default_nettype wire

// ==== host_model.sv ====
// host controller model driving the three control input pins
`timescale 1ns/1ns
`default_nettype none
module host_model #(
    parameter int HOLD = 30
) (
    input wire logic CLK,
    input wire logic [2:0] want,
    output logic [2:0] pins
);
    int held = HOLD;
    initial pins = 3'h0;
    // a level is never changed before it has stood hold cycles
    always @(posedge CLK) begin
        if (want != pins && held >= HOLD) begin
            pins <= want;
            held <= 0;
        end else if (held < HOLD) begin
            held <= held + 1;
        end
    end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the servo input conditioning block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic CLK = 0, RST = 1, WR = 0, RD = 0, POWER_UP = 0;
    logic [7:0] ADDR = 8'h00;
    logic [31:0] WDATA = 32'h0, RDATA;
    logic [15:0] MOTOR_SPEED = 16'h0, TRAVEL_OVERRUN = 16'h0;
    logic [15:0] MOTOR_MAX_SPEED = 16'h03E8;
    logic [9:0] LOAD_LEVEL = 10'h0;
    logic [2:0] want = 3'h0, pins;
    logic ALARM_CLEAR, DEV_CLEAR, PULSE_INHIBIT;
    logic OVERSPEED_FAULT, OVERLOAD_FAULT, TRAVEL_LIMIT_FAULT, IRQ;
    wire [2:0] outs = {ALARM_CLEAR, DEV_CLEAR, PULSE_INHIBIT};
    logic [31:0] exp_q[$];
    logic rd_d = 0;
    int n_errors = 0, checked = 0, seed = 2, t, mx;
    always #25 CLK = ~CLK;
    // short periods keep the run brief; expectations below use these values
    servo_input_filter_protection #(.P0_CYC(10), .P1_CYC(20), .P2_CYC(40),
        .P3_CYC(60), .ACLR_CYC(200)) u_servo_input_filter_protection (
        .CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .POWER_UP(POWER_UP), .ALARM_CLEAR_IN(pins[2]),
        .COUNTER_CLEAR_IN(pins[1]), .PULSE_INHIBIT_IN(pins[0]),
        .MOTOR_SPEED(MOTOR_SPEED), .MOTOR_MAX_SPEED(MOTOR_MAX_SPEED),
        .LOAD_LEVEL(LOAD_LEVEL), .TRAVEL_OVERRUN(TRAVEL_OVERRUN),
        .ALARM_CLEAR(ALARM_CLEAR), .DEV_CLEAR(DEV_CLEAR), .PULSE_INHIBIT(PULSE_INHIBIT),
        .OVERSPEED_FAULT(OVERSPEED_FAULT), .OVERLOAD_FAULT(OVERLOAD_FAULT),
        .TRAVEL_LIMIT_FAULT(TRAVEL_LIMIT_FAULT), .IRQ(IRQ));
    host_model u_host_model (.CLK(CLK), .want(want), .pins(pins));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic report_and_stop;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge CLK);
        RD <= 1'b1;
        ADDR <= a;
        exp_q.push_back(e);
        @(posedge CLK);
        RD <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    always @(posedge CLK) begin
        rd_d <= RD;
        if (rd_d)
            chk("rdata", exp_q.pop_front(), RDATA);
    end
    task automatic drv(input logic [15:0] s, input logic [9:0] l, input logic [15:0] o);
        @(posedge CLK);
        MOTOR_SPEED <= s;
        LOAD_LEVEL <= l;
        TRAVEL_OVERRUN <= o;
        repeat (3) @(posedge CLK);
        @(negedge CLK);
    endtask
    // t ends as the delay from pin change to output, 400 if none came
    task automatic pin(input int i, input logic v);
        @(posedge CLK);
        want[i] <= v;
        t = 0;
        while (pins[i] !== v && t < 100) begin
            @(negedge CLK);
            t++;
        end
        t = 0;
        while (outs[i] !== v && t < 400) begin
            @(negedge CLK);
            t++;
        end
    endtask
    task automatic pwr;
        @(posedge CLK);
        POWER_UP <= 1'b1;
        @(posedge CLK);
        POWER_UP <= 1'b0;
    endtask
    initial begin
        repeat (6) @(posedge CLK);
        RST <= 1'b0;
        for (int i = 0; i < 11; i++)
            rd(8'(4 * i), (i == 2) ? 32'hA : (i == 5) ? 32'h3 : 32'(i == 6));
        wr(8'h3C, 32'hFFFFFFFF);
        rd(8'h3C, 32'h0);
        wr(8'h24, 32'h1);
        drv(16'h04B1, 10'h0, 16'h0);
        chk("overspeed", 1, OVERSPEED_FAULT);
        chk("irq", 1, IRQ);
        rd(8'h20, 32'h1);
        drv(16'h04B0, 10'h0, 16'h0);
        chk("overspeed", 0, OVERSPEED_FAULT);
        rd(8'h20, 32'h1);
        rd(8'h20, 32'h0);
        drv(16'h0, 10'h0, 16'h0);
        chk("irq", 0, IRQ);
        wr(8'h04, 32'h1F4);
        drv(16'h01F5, 10'h0, 16'h0);
        chk("overspeed", 1, OVERSPEED_FAULT);
        drv(16'h01F4, 10'h0, 16'h0);
        chk("overspeed", 0, OVERSPEED_FAULT);
        wr(8'h04, 32'h0);
        for (int i = 0; i < 12; i++) begin
            t = 32'h400 + ($random(seed) & 32'hFF);
            mx = 32'h380 + ($random(seed) & 32'hFF);
            @(posedge CLK);
            MOTOR_MAX_SPEED <= 16'(mx);
            drv(16'(t), 10'h0, 16'h0);
            chk("overspeed", t * 5 > mx * 6, OVERSPEED_FAULT);
        end
        for (int i = 0; i < 3; i++) begin
            wr(8'h00, 32'(i * 100));
            t = (i == 1) ? 100 : 115;
            drv(16'h0, 10'(t), 16'h0);
            chk("overload", 0, OVERLOAD_FAULT);
            drv(16'h0, 10'(t + 1), 16'h0);
            chk("overload", 1, OVERLOAD_FAULT);
        end
        rd(8'h28, 32'h2);
        drv(16'h0, 10'h0, 16'h000A);
        chk("travel", 0, TRAVEL_LIMIT_FAULT);
        drv(16'h0, 10'h0, 16'h000B);
        chk("travel", 1, TRAVEL_LIMIT_FAULT);
        wr(8'h08, 32'h3E8);
        drv(16'h0, 10'h0, 16'h03E8);
        chk("travel", 0, TRAVEL_LIMIT_FAULT);
        wr(8'h14, 32'h0);
        pin(1, 1'b1);
        chk("clear ignored", 400, t);
        pin(1, 1'b0);
        for (int m = 1; m < 5; m++) begin
            // let the filtered copy settle so a mode change sees no stale level
            repeat (40) @(posedge CLK);
            wr(8'h14, 32'(m));
            pin(1, 1'b1);
            chk("clear delay", 1, (m % 2) ? t < 8 : t >= 20 && t < 60);
            @(negedge CLK);
            chk("clear level", m < 3, DEV_CLEAR);
            pin(1, 1'b0);
        end
        pin(0, 1'b1);
        chk("inhibit ignored", 400, t);
        pin(0, 1'b0);
        repeat (40) @(posedge CLK);
        wr(8'h18, 32'h0);
        pin(0, 1'b1);
        chk("inhibit delay", 1, t >= 20 && t <= 50);
        wr(8'h1C, 32'h4);
        pwr();
        pin(0, 1'b0);
        chk("inhibit direct", 1, t <= 15);
        // new filter and recognition settings wait for power-up
        wr(8'h0C, 32'h2);
        wr(8'h10, 32'h1);
        pin(2, 1'b1);
        chk("alarm delay", 1, t >= 195 && t <= 215);
        pin(2, 1'b0);
        repeat (40) @(posedge CLK);
        pwr();
        pin(2, 1'b1);
        chk("alarm filtered", 1, t >= 70 && t <= 170);
        report_and_stop();
    end
    initial begin
        #(50 * 20000);
        n_errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
